/* File: hdl/rcs_pkg.sv */
package rcs_pkg;

  // ---------------------------------------------------------------------
  // Register byte offsets.
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_IRQ_EN  = 8'h08;
  localparam logic [7:0] OFF_CMD_LO  = 8'h10;
  localparam logic [7:0] OFF_CMD_HI  = 8'h14;
  localparam logic [7:0] OFF_EVT_LO  = 8'h18;
  localparam logic [7:0] OFF_EVT_HI  = 8'h1C;

  // ---------------------------------------------------------------------
  // Field positions and reset values.
  // ---------------------------------------------------------------------
  localparam int          BIT_EVT_PROC = 17;
  localparam int          BIT_HALTED   = 16;
  localparam int          BIT_HOST_ERR = 10;
  localparam int          BIT_EVT_RDY  = 9;
  localparam int          BIT_CMD_RDY  = 8;
  localparam int          SRC_W        = 8;
  localparam int          OFS_W        = 12;
  localparam logic [31:0] STATUS_RST   = 32'h0001_0000;
  localparam logic [31:0] IRQ_EN_RST   = 32'h0000_0000;
  localparam logic [31:0] IRQ_EN_MASK  = 32'h0000_07FF;

  // Halt sequencing states.
  typedef enum logic [2:0] {
    RCS_RUN    = 3'b001,
    RCS_CANCEL = 3'b010,
    RCS_HALTED = 3'b100
  } rcs_run_t;

  // Register access request.
  typedef struct packed {
    logic        sel;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } rcs_req_t;

  // Events from the controller core, all on the same clock.
  typedef struct packed {
    logic             run;
    logic             int_when_ready;
    logic             evt_addr_valid;
    logic             cmd_fetched;
    logic             host_err;
    logic             evt_written;
    logic [OFS_W-1:0] evt_size;
    logic             evt_done;
    logic             cmds_idle;
    logic [SRC_W-1:0] src_irq;
  } rcs_core_t;

  // Complete state of the register bank.
  typedef struct packed {
    rcs_run_t         run_st;
    logic             evt_proc;
    logic             host_err;
    logic             evt_rdy;
    logic             cmd_rdy;
    logic [10:0]      irq_en;
    logic [61:0]      cmd_ptr;
    logic [51:0]      evt_base;
    logic [OFS_W-1:0] evt_ofs;
    logic [31:0]      rdata;
    logic             ack;
    logic             irq;
    logic             clr_active;
    logic             clr_evt_valid;
    logic             cancel;
  } rcs_state_t;

endpackage : rcs_pkg

/* File: hdl/rcs_regs.sv */
`timescale 1ns/10ps
// Summary of operation
// - Writing one clears a status flag.
// - Event processing means valid pointer and run.
// - Event ready drops event processing.
// - Run cleared drops processing, sets halted.
// - Halted is zero while running.
// - Halted resets to one, set on stop.
// - Host bus failure sets host error.
// - Host error clears the command-active bit.
// - Finished event writes set event ready.
// - Command taken sets ready flag if requested.
// - Source field has one bit per interface.
// - Source bits follow sources, software cannot write.
// - Enables reset zero; disabled flags still record.
// - Enables gate flags; clearing acknowledges interrupt.
// - Enabled source bit raises the interrupt.
// - Command pointer holds address bits 63:2.
// - Event base address never changed by hardware.
// - Offset advances by each event size.
// - Reserved bits read as zero.
// - Valid pointer taken, processing set, valid cleared.
// - Command read clears the command-active bit.
// - Stopping cancels pending commands before halting.
module rcs_regs (
  input  wire logic               clock,
  input  wire logic               nrst,
  input  wire rcs_pkg::rcs_req_t  req,
  input  wire rcs_pkg::rcs_core_t core,
  output logic [31:0]             rdata,
  output logic                    ack,
  output logic                    irq,
  output logic                    clr_active,
  output logic                    clr_evt_valid,
  output logic                    cancel_cmds,
  output logic                    halted,
  output logic                    evt_proc,
  output logic [63:0]             cmd_addr,
  output logic [63:0]             evt_addr
);

  rcs_pkg::rcs_state_t s_q;
  rcs_pkg::rcs_state_t s_d;
  logic [31:0]         status_rd;
  logic                wr_sts;
  logic [31:0]         w1c;

  // ---------------------------------------------------------------------
  // Status word as read by software; reserved bits are zero.
  // ---------------------------------------------------------------------
  always_comb begin
    status_rd                        = '0;
    status_rd[rcs_pkg::BIT_EVT_PROC] = s_q.evt_proc;
    status_rd[rcs_pkg::BIT_HALTED]   = (s_q.run_st == rcs_pkg::RCS_HALTED);
    status_rd[rcs_pkg::BIT_HOST_ERR] = s_q.host_err;
    status_rd[rcs_pkg::BIT_EVT_RDY]  = s_q.evt_rdy;
    status_rd[rcs_pkg::BIT_CMD_RDY]  = s_q.cmd_rdy;
    status_rd[rcs_pkg::SRC_W-1:0]    = core.src_irq;
  end

  // Write strobe for the status register and its one-to-clear mask.
  assign wr_sts = req.sel && req.wr && (req.addr == rcs_pkg::OFF_STATUS);
  assign w1c    = wr_sts ? req.wdata : 32'h0000_0000;

  // ---------------------------------------------------------------------
  // Next-state logic.
  // ---------------------------------------------------------------------
  always_comb begin
    s_d               = s_q;
    s_d.ack           = req.sel;
    s_d.clr_active    = 1'b0;
    s_d.clr_evt_valid = 1'b0;

    // Halt sequencing: cancel pending commands, then report halted.
    case (s_q.run_st)
      rcs_pkg::RCS_RUN: begin
        if (!core.run) begin
          s_d.run_st   = rcs_pkg::RCS_CANCEL;
          s_d.evt_proc = 1'b0;
        end
      end
      rcs_pkg::RCS_CANCEL: begin
        if (core.cmds_idle) begin
          s_d.run_st = rcs_pkg::RCS_HALTED;
        end
      end
      rcs_pkg::RCS_HALTED: begin
        if (core.run) begin
          s_d.run_st = rcs_pkg::RCS_RUN;
        end
      end
      default: begin
        s_d.run_st = rcs_pkg::RCS_HALTED;
      end
    endcase
    // Running has priority: halted reads zero from the cycle after run is seen set.
    if (core.run) begin
      s_d.run_st = rcs_pkg::RCS_RUN;
    end
    s_d.cancel = (s_d.run_st == rcs_pkg::RCS_CANCEL);

    // Taking a newly valid event pointer enables event processing.
    if (core.run && core.evt_addr_valid && !s_q.evt_proc
        && !s_q.clr_evt_valid) begin
      s_d.evt_proc      = 1'b1;
      s_d.clr_evt_valid = 1'b1;
    end
    // Running offset into the event buffer; the base is left alone.
    if (core.evt_written && s_q.evt_proc) begin
      s_d.evt_ofs = s_q.evt_ofs + core.evt_size;
    end
    // Completed buffer: flag it and stop event processing.
    if (core.evt_done && s_q.evt_proc) begin
      s_d.evt_proc = 1'b0;
    end
    if (!core.run) begin
      s_d.evt_proc = 1'b0;
    end

    // Command handshake and host error both drop the active bit.
    if (core.cmd_fetched || core.host_err) begin
      s_d.clr_active = 1'b1;
    end

    // Sticky flags: a write of one clears, a new event wins over it.
    s_d.host_err = (s_q.host_err && !w1c[rcs_pkg::BIT_HOST_ERR])
                   || core.host_err;
    s_d.evt_rdy  = (s_q.evt_rdy && !w1c[rcs_pkg::BIT_EVT_RDY])
                   || (core.evt_done && s_q.evt_proc);
    s_d.cmd_rdy  = (s_q.cmd_rdy && !w1c[rcs_pkg::BIT_CMD_RDY])
                   || (core.cmd_fetched && core.int_when_ready);

    // Register writes and reads.
    if (req.sel && req.wr) begin
      case (req.addr)
        rcs_pkg::OFF_IRQ_EN: s_d.irq_en = req.wdata[10:0];
        rcs_pkg::OFF_CMD_LO: s_d.cmd_ptr[29:0] = req.wdata[31:2];
        rcs_pkg::OFF_CMD_HI: s_d.cmd_ptr[61:30] = req.wdata;
        rcs_pkg::OFF_EVT_LO: begin
          s_d.evt_base[19:0] = req.wdata[31:12];
          s_d.evt_ofs        = req.wdata[rcs_pkg::OFS_W-1:0];
        end
        rcs_pkg::OFF_EVT_HI: s_d.evt_base[51:20] = req.wdata;
        default: s_d.irq_en = s_q.irq_en;
      endcase
    end
    s_d.rdata = 32'h0000_0000;
    if (req.sel && !req.wr) begin
      case (req.addr)
        rcs_pkg::OFF_STATUS: s_d.rdata = status_rd;
        rcs_pkg::OFF_IRQ_EN: s_d.rdata = {21'h0_0000, s_q.irq_en};
        rcs_pkg::OFF_CMD_LO: s_d.rdata = {s_q.cmd_ptr[29:0], 2'b00};
        rcs_pkg::OFF_CMD_HI: s_d.rdata = s_q.cmd_ptr[61:30];
        rcs_pkg::OFF_EVT_LO: s_d.rdata = {s_q.evt_base[19:0], s_q.evt_ofs};
        rcs_pkg::OFF_EVT_HI: s_d.rdata = s_q.evt_base[51:20];
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end

    // Level interrupt from enabled flags and enabled sources.
    s_d.irq = |(s_q.irq_en & status_rd[10:0]);
  end

  // ---------------------------------------------------------------------
  // State register.
  // ---------------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_q          <= '0;
      s_q.run_st   <= rcs_pkg::RCS_HALTED;
      s_q.irq_en   <= rcs_pkg::IRQ_EN_RST[10:0];
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register.
  assign rdata         = s_q.rdata;
  assign ack           = s_q.ack;
  assign irq           = s_q.irq;
  assign clr_active    = s_q.clr_active;
  assign clr_evt_valid = s_q.clr_evt_valid;
  assign cancel_cmds   = s_q.cancel;
  assign halted        = (s_q.run_st == rcs_pkg::RCS_HALTED);
  assign evt_proc      = s_q.evt_proc;
  assign cmd_addr      = {s_q.cmd_ptr, 2'b00};
  assign evt_addr      = {s_q.evt_base, s_q.evt_ofs};

  // ---------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // Halted reads zero one cycle after run is seen high.
  halted_run_a: assert property (
    core.run |=> !halted)
    else $error("halted set while run is one");

  // A stop followed by an idle core ends in the halted state.
  stop_halt_a: assert property (
    $fell(core.run) ##1 core.cmds_idle && !core.run |=> halted)
    else $error("halted not set after stop");

  // Event processing is dropped as soon as run is low.
  stop_proc_a: assert property (
    !core.run |=> !evt_proc)
    else $error("event processing kept after stop");

  // Halting waits for the core to finish cancelling commands.
  cancel_hold_a: assert property (
    cancel_cmds && !core.cmds_idle && !core.run
    |=> cancel_cmds && !halted)
    else $error("halted before commands were cancelled");

  // A host bus failure records the flag and drops the active bit.
  host_err_a: assert property (
    core.host_err |=> clr_active && s_q.host_err)
    else $error("host error not recorded");

  // A finished buffer raises event ready and ends processing.
  evt_rdy_a: assert property (
    core.evt_done && evt_proc |=> s_q.evt_rdy && !evt_proc)
    else $error("event ready without dropping processing");

  // A zero in the written word leaves the flag alone.
  w1c_keep_a: assert property (
    s_q.evt_rdy && wr_sts && !req.wdata[rcs_pkg::BIT_EVT_RDY]
    |=> s_q.evt_rdy)
    else $error("zero write cleared a flag");

  // A one in the written word clears the flag when no set competes.
  w1c_clear_a: assert property (
    s_q.cmd_rdy && wr_sts && req.wdata[rcs_pkg::BIT_CMD_RDY]
    && !core.cmd_fetched |=> !s_q.cmd_rdy)
    else $error("one write left a flag set");

  // The ready flag is set only when it was requested.
  cmd_rdy_a: assert property (
    core.cmd_fetched && !core.int_when_ready && !s_q.cmd_rdy
    |=> !s_q.cmd_rdy)
    else $error("ready flag set without request");

  // A taken command with the request bit set raises the flag.
  cmd_rdy_set_a: assert property (
    core.cmd_fetched && core.int_when_ready
    |=> s_q.cmd_rdy && clr_active)
    else $error("ready flag not set after command taken");

  // Each written event moves the offset by its size.
  offset_a: assert property (
    core.evt_written && evt_proc && !req.sel
    |=> evt_addr[11:0] == $past(evt_addr[11:0]) + $past(core.evt_size))
    else $error("offset not advanced");

  // Only a bus write may change the event buffer base.
  base_keep_a: assert property (
    !(req.sel && req.wr)
    |=> evt_addr[63:12] == $past(evt_addr[63:12]))
    else $error("event base changed by hardware");

  // An enabled host error flag drives the interrupt.
  irq_level_a: assert property (
    s_q.irq_en[rcs_pkg::BIT_HOST_ERR] && s_q.host_err |=> irq)
    else $error("enabled flag without interrupt");

  // An enabled source bit drives the interrupt.
  src_irq_a: assert property (
    (|(s_q.irq_en[rcs_pkg::SRC_W-1:0] & core.src_irq)) |=> irq)
    else $error("enabled source without interrupt");

  // With no enabled cause left, the interrupt is released.
  irq_quiet_a: assert property (
    !(|(s_q.irq_en & status_rd[10:0])) |=> !irq)
    else $error("interrupt without an enabled cause");

  // Source bits read back exactly as the interfaces report them.
  src_read_a: assert property (
    req.sel && !req.wr && req.addr == rcs_pkg::OFF_STATUS
    |=> rdata[rcs_pkg::SRC_W-1:0] == $past(core.src_irq))
    else $error("source bits differ from the sources");

  // Reserved status bits read as zero.
  rsvd_zero_a: assert property (
    req.sel && !req.wr && req.addr == rcs_pkg::OFF_STATUS
    |=> rdata[31:18] == 14'h0000 && rdata[15:11] == 5'h00)
    else $error("reserved status bit read as one");

  // Reserved enable bits read as zero.
  rsvd_en_a: assert property (
    req.sel && !req.wr && req.addr == rcs_pkg::OFF_IRQ_EN
    |=> rdata[31:11] == 21'h0_0000)
    else $error("reserved enable bit read as one");

  // A valid pointer is taken once while running.
  take_ptr_a: assert property (
    core.run && core.evt_addr_valid && !evt_proc && !clr_evt_valid
    |=> evt_proc && clr_evt_valid)
    else $error("valid event pointer not taken");

  // Main scenarios: stop, buffer, interrupt, pointer and command.
  stop_cov: cover property ($fell(core.run) ##[1:20] halted);
  evt_cov: cover property (evt_proc ##[1:50] s_q.evt_rdy);
  irq_cov: cover property (irq ##[1:20] !irq);
  take_cov: cover property (clr_evt_valid ##1 evt_proc);
  ready_cov: cover property (clr_active && s_q.cmd_rdy);

endmodule : rcs_regs

/* File: verif/rcs_regs_tb.sv */
`timescale 1ns/10ps
module rcs_regs_tb;
  // ----------------------------------------------------------------------
  // Signals and constants.
  // ----------------------------------------------------------------------
  localparam logic [63:0] ONE  = 64'h0000_0000_0000_0001;
  localparam logic [63:0] ZERO = 64'h0000_0000_0000_0000;
  logic               clock;
  logic               nrst;
  rcs_pkg::rcs_req_t  req;
  rcs_pkg::rcs_core_t core;
  logic [31:0]        rdata;
  logic               ack, irq, clr_active, clr_evt_valid;
  logic               cancel_cmds, halted, evt_proc;
  logic [63:0]        cmd_addr, evt_addr;
  int                 failures;
  int                 num_checks;

  rcs_regs rcs_regs_inst (.clock(clock), .nrst(nrst), .req(req),
    .core(core), .rdata(rdata), .ack(ack), .irq(irq),
    .clr_active(clr_active), .clr_evt_valid(clr_evt_valid),
    .cancel_cmds(cancel_cmds), .halted(halted), .evt_proc(evt_proc),
    .cmd_addr(cmd_addr), .evt_addr(evt_addr));

  // ----------------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp,
                       input string msg);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick

  // One access: request in one cycle, answer sampled in the next.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(negedge clock);
    req = '{sel: 1'b1, wr: w, addr: a, wdata: wd};
    @(negedge clock);
    req.sel = 1'b0;
    check(64'(ack), ONE, "access not acknowledged");
    rd = rdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string m);
    logic [31:0] d;
    bus(1'b0, a, 32'h0000_0000, d);
    check(64'(d), 64'(e), m);
  endtask : rd

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------
  task automatic t_reset();
    check(64'(halted), ONE, "halted after reset");
    rd(rcs_pkg::OFF_STATUS, rcs_pkg::STATUS_RST, "status reset");
    rd(rcs_pkg::OFF_IRQ_EN, rcs_pkg::IRQ_EN_RST, "enable reset");
    rd(8'h0C, 32'h0000_0000, "unmapped read");
  endtask : t_reset

  task automatic t_host_err();
    wr(rcs_pkg::OFF_IRQ_EN, 32'hFFFF_FFFF);
    rd(rcs_pkg::OFF_IRQ_EN, rcs_pkg::IRQ_EN_MASK, "enable mask");
    wr(rcs_pkg::OFF_IRQ_EN, 32'h0000_0400);
    tick(1);
    core.host_err = 1'b1;
    tick(1);
    core.host_err = 1'b0;
    check(64'(clr_active), ONE, "active not cleared");
    tick(1);
    check(64'(irq), ONE, "host error irq");
    rd(rcs_pkg::OFF_STATUS, 32'h0001_0400, "host error flag");
    wr(rcs_pkg::OFF_STATUS, 32'h0000_0000);
    rd(rcs_pkg::OFF_STATUS, 32'h0001_0400, "zero write kept");
    wr(rcs_pkg::OFF_STATUS, 32'h0000_0400);
    rd(rcs_pkg::OFF_STATUS, 32'h0001_0000, "one write clears");
    check(64'(irq), ZERO, "irq acknowledged");
  endtask : t_host_err

  task automatic t_cmd_ready();
    for (int i = 0; i < 2; i++) begin
      core.int_when_ready = i[0];
      tick(1);
      core.cmd_fetched = 1'b1;
      tick(1);
      core.cmd_fetched = 1'b0;
      check(64'(clr_active), ONE, "command taken");
      rd(rcs_pkg::OFF_STATUS, {23'h00_0080, i[0], 8'h00}, "ready");
    end
    check(64'(irq), ZERO, "disabled ready irq");
    wr(rcs_pkg::OFF_STATUS, 32'h0000_0100);
  endtask : t_cmd_ready

  task automatic t_event();
    wr(rcs_pkg::OFF_EVT_LO, 32'h0000_5000);
    wr(rcs_pkg::OFF_EVT_HI, 32'h1234_0000);
    core.run = 1'b1;
    core.evt_addr_valid = 1'b1;
    tick(1);
    check(64'(clr_evt_valid), ONE, "valid not cleared");
    check(64'(evt_proc), ONE, "processing on");
    check(64'(halted), ZERO, "halted while run");
    core.evt_addr_valid = 1'b0;
    core.evt_written = 1'b1;
    core.evt_size = 12'h010;
    tick(1);
    core.evt_size = 12'h018;
    tick(1);
    core.evt_written = 1'b0;
    tick(1);
    check(evt_addr, 64'h1234_0000_0000_5028, "offset sum");
    rd(rcs_pkg::OFF_EVT_LO, 32'h0000_5028, "event low word");
    rd(rcs_pkg::OFF_EVT_HI, 32'h1234_0000, "event high word");
    core.evt_done = 1'b1;
    tick(1);
    core.evt_done = 1'b0;
    tick(1);
    check(64'(evt_proc), ZERO, "processing off");
    rd(rcs_pkg::OFF_STATUS, 32'h0000_0200, "event ready");
    wr(rcs_pkg::OFF_STATUS, 32'h0000_0200);
  endtask : t_event

  task automatic t_stop();
    core.evt_addr_valid = 1'b1;
    tick(1);
    check(64'(evt_proc), ONE, "processing before stop");
    core.evt_addr_valid = 1'b0;
    core.run = 1'b0;
    tick(1);
    check(64'(cancel_cmds), ONE, "cancel on stop");
    check(64'(evt_proc), ZERO, "processing off on stop");
    tick(3);
    check(64'(halted), ZERO, "halt before idle");
    core.cmds_idle = 1'b1;
    tick(2);
    core.cmds_idle = 1'b0;
    check(64'(halted), ONE, "halted after stop");
    check(64'(cancel_cmds), ZERO, "cancel ended");
  endtask : t_stop

  task automatic t_src();
    wr(rcs_pkg::OFF_IRQ_EN, 32'h0000_0004);
    core.src_irq = 8'h01;
    tick(3);
    check(64'(irq), ZERO, "unenabled source");
    core.src_irq = 8'h05;
    wr(rcs_pkg::OFF_STATUS, 32'h0000_00FF);
    rd(rcs_pkg::OFF_STATUS, 32'h0001_0005, "source bits");
    check(64'(irq), ONE, "enabled source");
    core.src_irq = 8'h00;
    rd(rcs_pkg::OFF_STATUS, 32'h0001_0000, "source cleared");
    tick(1);
    check(64'(irq), ZERO, "source irq off");
  endtask : t_src

  task automatic t_cmd_ptr();
    wr(rcs_pkg::OFF_CMD_LO, 32'hABCD_EF03);
    wr(rcs_pkg::OFF_CMD_HI, 32'h0000_00FF);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(rcs_pkg::OFF_CMD_LO, 32'hABCD_EF00, "pointer low bits");
    rd(rcs_pkg::OFF_CMD_HI, 32'h0000_00FF, "pointer high word");
    check(cmd_addr, 64'h0000_00FF_ABCD_EF00, "pointer out");
  endtask : t_cmd_ptr

  // ----------------------------------------------------------------------
  // Clock, reset, sequence and watchdog.
  // ----------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Main sequence; inputs change on the falling edge only.
  initial begin
    failures = 0;
    num_checks = 0;
    nrst = 1'b0;
    req = '0;
    core = '0;
    tick(12);
    nrst = 1'b1;
    t_reset();
    t_host_err();
    t_cmd_ready();
    t_event();
    t_stop();
    t_src();
    t_cmd_ptr();
    tally_and_finish();
  end

  // Cuts a hang short well after the hundred or so cycles needed.
  initial begin
    #(3000 * 50);
    failures++;
    tally_and_finish();
  end
endmodule : rcs_regs_tb
